//--- hw/timer_pkg.sv
/*
  Shared constants and carrier types for the gated 16-bit timer/counter.
  Assumes a 32-bit classic Wishbone register bus and one 50 MHz system clock.
*/
package timer_pkg;

  // ----------------------------------------
  // Register map, one aligned word each.
  // ----------------------------------------
  localparam logic [4:0] ADDR_COUNT_LOW = 5'h00;
  localparam logic [4:0] ADDR_COUNT_HIGH = 5'h04;
  localparam logic [4:0] ADDR_TIMER_CTRL = 5'h08;
  localparam logic [4:0] ADDR_GATE_CTRL = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h10;

  localparam int COUNT_W = 16;
  localparam int PRESC_W = 3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Instruction clock is the system clock divided by four.
  localparam logic [1:0] INSTR_LAST_PHASE = 2'h3;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // ----------------------------------------
  // Clock source encodings.
  // ----------------------------------------
  typedef enum logic [1:0] {
    SRC_INSTR = 2'b00,
    SRC_SYSTEM = 2'b01,
    SRC_EXTERNAL = 2'b10,
    SRC_CAPSENSE = 2'b11
  } clockSource_type;

  // Timer control word, low byte of its register.
  typedef struct packed {
    clockSource_type clockSelectField;
    logic [1:0] prescaleSelectField;
    logic crystalOscEnable;
    logic syncDisableBit;
    logic unused1;
    logic timerOnBit;
  } timerCtrl_type;

  // Gate control word, low byte of its register.
  typedef struct packed {
    logic gateEnableBit;
    logic gatePolarityBit;
    logic [3:0] unused5;
    logic gateValue;
    logic unused0;
  } gateCtrl_type;

  localparam timerCtrl_type TIMER_CTRL_RESET = 8'h00;
  localparam gateCtrl_type GATE_CTRL_RESET = 8'h00;
  localparam int OVF_FLAG_BIT = 0;

endpackage

//--- hw/sync_two_stage.sv
/*
  Two flip-flop synchroniser for a group of level inputs.
  Assumes inputs are asynchronous to clock; only the second stage is read outside.
*/
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_r <= '0;
      syncOut <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end

endmodule

//--- hw/prescale_divider.sv
/*
  Prescale counter dividing an input tick stream by 1, 2, 4 or 8.
  Assumes tick and clear come from logic on the same clock.
*/
module prescale_divider (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] divSelect,
  output logic pulse,
  output logic [timer_pkg::PRESC_W-1:0] prescCount
);

  logic [timer_pkg::PRESC_W-1:0] cnt_r;
  logic [timer_pkg::PRESC_W-1:0] mask;

  // The mask is all ones below the selected power of two.
  assign mask = timer_pkg::PRESC_W'((4'h1 << divSelect) - 4'h1);
  assign pulse = tick && ((cnt_r & mask) == mask) && !clear;
  assign prescCount = cnt_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clear) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= (cnt_r & mask) == mask ? '0 : cnt_r + 1'b1;
    end
  end

endmodule

//--- hw/gated_timer.sv
/*
  Gated 16-bit timer/counter with a classic Wishbone slave.
  Assumes one 50 MHz clock, a synchronous active-low reset and pins from outside
  the clock domain; asynchronous counting is modelled on the same clock.
*/
// Design decisions made here: the Wishbone register port and the register addresses.

module gated_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic externalClockPin,
  input wire logic crystalInputPin,
  input wire logic capSenseOsc,
  input wire logic gateInputPin,
  input wire logic sleepMode,
  output logic crystalAmpEnable,
  output logic overflowFlag,
  output logic wakeRequest
);

  // ----------------------------------------
  // Register state.
  // ----------------------------------------
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  timer_pkg::timerCtrl_type timerCtrl_r;
  timer_pkg::gateCtrl_type gateCtrl_r;
  logic overflowFlag_r;
  logic ack_r;
  logic [31:0] readData_r;
  logic wake_r;
  logic ampEnable_r;

  // ----------------------------------------
  // Bus decode.
  // ----------------------------------------
  logic busReq;
  logic busWrite;
  logic laneZero;
  logic writeLow;
  logic writeHigh;
  logic writeCount;
  logic writeTimerCtrl;
  logic writeGateCtrl;
  logic writeStatus;
  logic [7:0] wrByte;

  assign busReq = wb_cyc_i && wb_stb_i;
  // A write takes effect at the edge where ack is high.
  assign busWrite = busReq && wb_we_i && ack_r;
  assign laneZero = wb_sel_i[0];
  assign wrByte = wb_dat_i[7:0];
  assign writeLow = busWrite && laneZero && wb_adr_i == timer_pkg::ADDR_COUNT_LOW;
  assign writeHigh = busWrite && laneZero && wb_adr_i == timer_pkg::ADDR_COUNT_HIGH;
  assign writeCount = writeLow || writeHigh;
  assign writeTimerCtrl = busWrite && laneZero && wb_adr_i == timer_pkg::ADDR_TIMER_CTRL;
  assign writeGateCtrl = busWrite && laneZero && wb_adr_i == timer_pkg::ADDR_GATE_CTRL;
  assign writeStatus = busWrite && laneZero && wb_adr_i == timer_pkg::ADDR_STATUS;

  // ----------------------------------------
  // Pin synchronisers.
  // ----------------------------------------
  logic [3:0] pinsSync;
  logic extPinLevel;
  logic crystalLevel;
  logic capLevel;
  logic gateLevel;

  sync_two_stage #(
    .WIDTH(4)
  ) pinSync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn({gateInputPin, capSenseOsc, crystalInputPin, externalClockPin}),
    .syncOut(pinsSync)
  );

  assign extPinLevel = pinsSync[0];
  assign crystalLevel = pinsSync[1];
  assign capLevel = pinsSync[2];
  assign gateLevel = pinsSync[3];

  // ----------------------------------------
  // Clock source selection.
  // ----------------------------------------
  logic isExternal;
  logic asyncMode;
  logic extLevel;
  logic extDelay_r;
  logic extPrev_r;
  logic extSample;
  logic extRise;
  logic extFall;
  logic [1:0] phase_r;
  logic instrTick;
  logic armed_r;
  logic srcTick;
  logic sleepAllowed;

  // An external source is either the pin, the crystal or the sensing oscillator.
  assign isExternal = timerCtrl_r.clockSelectField == timer_pkg::SRC_EXTERNAL ||
                      timerCtrl_r.clockSelectField == timer_pkg::SRC_CAPSENSE;
  assign asyncMode = timerCtrl_r.syncDisableBit;

  always_comb begin
    case (timerCtrl_r.clockSelectField)
      timer_pkg::SRC_CAPSENSE: extLevel = capLevel;
      timer_pkg::SRC_EXTERNAL: extLevel = timerCtrl_r.crystalOscEnable ? crystalLevel
                                                                      : extPinLevel;
      default: extLevel = 1'b0;
    endcase
  end

  // The synchronised path adds one stage aligned to the system clock; the
  // unsynchronised path skips it, so a mode switch can gain or lose one edge.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extDelay_r <= 1'b0;
    end else begin
      extDelay_r <= extLevel;
    end
  end
  assign extSample = asyncMode ? extLevel : extDelay_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extPrev_r <= 1'b0;
    end else begin
      extPrev_r <= extSample;
    end
  end

  assign extRise = extSample && !extPrev_r;
  assign extFall = !extSample && extPrev_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_r <= timer_pkg::PHASE_RESET;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign instrTick = phase_r == timer_pkg::INSTR_LAST_PHASE;
  // A falling edge must be seen before the first counted rising edge.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (!timerCtrl_r.timerOnBit || writeCount) begin
      armed_r <= 1'b0;
    end else if (extFall) begin
      armed_r <= 1'b1;
    end
  end

  // In sleep only the unsynchronised external path keeps counting.
  assign sleepAllowed = !sleepMode || (asyncMode && isExternal);
  always_comb begin
    case (timerCtrl_r.clockSelectField)
      timer_pkg::SRC_INSTR: srcTick = instrTick;
      timer_pkg::SRC_SYSTEM: srcTick = 1'b1;
      default: srcTick = extRise && armed_r;
    endcase
  end

  // ----------------------------------------
  // Gate and enable.
  // ----------------------------------------
  logic gatePermit;
  logic runEnable;
  logic countTick;
  logic incPulse;
  logic [timer_pkg::PRESC_W-1:0] prescCount;

  assign gatePermit = !gateCtrl_r.gateEnableBit ||
                      (gateLevel == gateCtrl_r.gatePolarityBit);
  assign runEnable = timerCtrl_r.timerOnBit && gatePermit;
  assign countTick = srcTick && runEnable && sleepAllowed;

  prescale_divider prescaler (
    .clock(clock),
    .rst_n(rst_n),
    .tick(countTick),
    .clear(writeCount),
    .divSelect(timerCtrl_r.prescaleSelectField),
    .pulse(incPulse),
    .prescCount(prescCount)
  );

  // ----------------------------------------
  // Count register.
  // ----------------------------------------
  // A byte write wins over a coinciding increment; software should stop first.
  always_comb begin
    count_nxt = count_r;
    if (writeLow) begin
      count_nxt = {count_r[15:8], wrByte};
    end else if (writeHigh) begin
      count_nxt = {wrByte, count_r[7:0]};
    end else if (incPulse) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_r <= timer_pkg::COUNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Set wins over a clear in the same cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      overflowFlag_r <= 1'b0;
    end else if (incPulse && !writeCount && count_r == timer_pkg::COUNT_MAX) begin
      overflowFlag_r <= 1'b1;
    end else if (writeStatus && !wrByte[timer_pkg::OVF_FLAG_BIT]) begin
      overflowFlag_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timerCtrl_r <= timer_pkg::TIMER_CTRL_RESET;
    end else if (writeTimerCtrl) begin
      timerCtrl_r <= wrByte;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gateCtrl_r <= timer_pkg::GATE_CTRL_RESET;
    end else if (writeGateCtrl) begin
      gateCtrl_r <= wrByte;
    end
  end

  // The amplifier follows its enable bit and ignores sleep on purpose.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ampEnable_r <= 1'b0;
    end else begin
      ampEnable_r <= timerCtrl_r.crystalOscEnable;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= sleepMode && overflowFlag_r;
    end
  end

  // ----------------------------------------
  // Wishbone answer.
  // ----------------------------------------
  timer_pkg::gateCtrl_type gateView;
  always_comb begin
    gateView = gateCtrl_r;
    gateView.gateValue = gateLevel;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq && !ack_r;
    end
  end

  // One clock domain makes every byte read coherent without extra latching.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readData_r <= timer_pkg::WORD_ZERO;
    end else if (busReq && !ack_r) begin
      case (wb_adr_i)
        timer_pkg::ADDR_COUNT_LOW: readData_r <= {24'h00_0000, count_r[7:0]};
        timer_pkg::ADDR_COUNT_HIGH: readData_r <= {24'h00_0000, count_r[15:8]};
        timer_pkg::ADDR_TIMER_CTRL: readData_r <= {24'h00_0000, timerCtrl_r};
        timer_pkg::ADDR_GATE_CTRL: readData_r <= {24'h00_0000, gateView};
        timer_pkg::ADDR_STATUS: readData_r <= {31'h0000_0000, overflowFlag_r};
        default: readData_r <= timer_pkg::WORD_ZERO;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = readData_r;
  assign crystalAmpEnable = ampEnable_r;
  assign overflowFlag = overflowFlag_r;
  assign wakeRequest = wake_r;

  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence busStart;
    busReq && !ack_r;
  endsequence
  sequence ackPulse;
    ack_r ##1 !ack_r;
  endsequence
  a_bus_ack_pulse: assert property (busStart |=> ackPulse)
    else $error("ack not a single cycle after request");
  a_low_byte_write: assert property (writeLow |=> count_r[7:0] == $past(wrByte))
    else $error("low byte write not applied");
  a_off_holds_count: assert property (
    !timerCtrl_r.timerOnBit && !writeCount |=> count_r == $past(count_r))
    else $error("count moved while timer off");
  a_prescale_write_clear: assert property (writeCount |=> prescCount == '0)
    else $error("prescaler not cleared by count write");
  a_write_disarms_edge: assert property (writeCount |=> !armed_r)
    else $error("counter still armed after count write");
  a_gate_blocks_count: assert property (
    gateCtrl_r.gateEnableBit && (gateLevel != gateCtrl_r.gatePolarityBit) && !writeCount
    |=> count_r == $past(count_r))
    else $error("count moved with gate closed");
  a_rollover_sets_flag: assert property (
    incPulse && !writeCount && count_r == timer_pkg::COUNT_MAX
    |=> overflowFlag_r && count_r == timer_pkg::COUNT_RESET)
    else $error("rollover did not set flag");
  a_flag_sticky: assert property (
    overflowFlag_r && !writeStatus |=> overflowFlag_r)
    else $error("overflow flag dropped without software");
  a_system_rate: assert property (
    timerCtrl_r.clockSelectField == timer_pkg::SRC_SYSTEM && runEnable && !sleepMode &&
    timerCtrl_r.prescaleSelectField == 2'h0 && !writeCount
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("system clock source missed a count");
  a_instr_rate: assert property (
    timerCtrl_r.clockSelectField == timer_pkg::SRC_INSTR && !instrTick |-> !countTick)
    else $error("instruction source ticked off phase");
endmodule

//--- sim/pin_partner.sv
/*
  Far-side model: external clock pin, crystal oscillator, capacitive oscillator, gate pin.
  Assumes the bench changes its controls just after rising clock edges.
*/
module pin_partner (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic runExt,
  input wire logic gateLevel,
  input wire logic crystalAmpEnable,
  output logic externalClockPin,
  output logic crystalInputPin,
  output logic capSenseOsc,
  output logic gateInputPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] extCnt_r;
  logic [2:0] xtalCnt_r;
  logic [2:0] capCnt_r;

  // The pin idles low between bursts, so a burst of 8n clocks gives exactly n rises.
  always_ff @(posedge clock) begin
    extCnt_r <= runExt ? extCnt_r + 3'h1 : 3'h0;
  end
  assign externalClockPin = extCnt_r[2];

  // The crystal swings only while its amplifier is enabled; sleep does not stop it.
  always_ff @(posedge clock) begin
    if (!rst_n || !crystalAmpEnable) begin
      xtalCnt_r <= 3'h0;
      crystalInputPin <= 1'b0;
    end else if (xtalCnt_r == 3'h5) begin
      xtalCnt_r <= 3'h0;
      crystalInputPin <= ~crystalInputPin;
    end else begin
      xtalCnt_r <= xtalCnt_r + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || capCnt_r == 3'h4) begin
      capCnt_r <= 3'h0;
      capSenseOsc <= rst_n & ~capSenseOsc;
    end else begin
      capCnt_r <= capCnt_r + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    gateInputPin <= gateLevel;
  end
endmodule

//--- sim/gated_16bit_timer_counter_tb_top.sv
/*
  Self-checking bench for the gated timer over classic Wishbone.
  Assumes the package, design files and pin partner model are compiled first.
*/
module gated_16bit_timer_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] ctrl;
    logic [7:0] gctrl;
    logic gate;
    logic ext;
    int div;
  } rowCase_type;
  localparam int RUN = 240;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, ampEn, ovf, wake, extPin, xtalPin, capPin, gatePin;
  logic sleepMode = 1'b0;
  logic runExt = 1'b0;
  logic gateLevel = 1'b0;
  logic [7:0] q;
  logic [15:0] cnt;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int ctr;
  rowCase_type r;
  rowCase_type rows[16] = '{
    '{8'h41, 8'h00, 1'b0, 1'b0, 1}, '{8'h51, 8'h00, 1'b0, 1'b0, 2},
    '{8'h61, 8'h00, 1'b0, 1'b0, 4}, '{8'h71, 8'h00, 1'b0, 1'b0, 8},
    '{8'h01, 8'h00, 1'b0, 1'b0, 4}, '{8'h11, 8'h00, 1'b0, 1'b0, 8},
    '{8'h40, 8'h00, 1'b0, 1'b0, 0}, '{8'hC1, 8'h00, 1'b0, 1'b0, 10},
    '{8'h81, 8'h00, 1'b0, 1'b1, 8}, '{8'h85, 8'h00, 1'b0, 1'b1, 8},
    '{8'h89, 8'h00, 1'b0, 1'b0, 12}, '{8'h41, 8'h80, 1'b0, 1'b0, 1},
    '{8'h41, 8'h80, 1'b1, 1'b0, 0}, '{8'h41, 8'hC0, 1'b1, 1'b0, 1},
    '{8'h41, 8'hC0, 1'b0, 1'b0, 0}, '{8'h40, 8'h80, 1'b0, 1'b0, 0}
  };

  always #10 clock = ~clock;

  gated_timer dut_u (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .externalClockPin(extPin), .crystalInputPin(xtalPin),
    .capSenseOsc(capPin), .gateInputPin(gatePin), .sleepMode(sleepMode),
    .crystalAmpEnable(ampEn), .overflowFlag(ovf), .wakeRequest(wake));
  pin_partner part_u (.clock(clock), .rst_n(rst_n), .runExt(runExt), .gateLevel(gateLevel),
    .crystalAmpEnable(ampEn), .externalClockPin(extPin), .crystalInputPin(xtalPin),
    .capSenseOsc(capPin), .gateInputPin(gatePin));

  // ----------------------------------------
  // Bus cycles and comparisons.
  // ----------------------------------------
  // The request stands until ack is sampled high at a rising edge; read data is taken there.
  task automatic wbCycle(input logic [4:0] a, input logic w, input logic [7:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    wbCycle(a, 1'b1, d);
  endtask

  task automatic check(input string name, input logic [15:0] lo, input logic [15:0] hi,
                       input logic [15:0] got);
    n_tests++;
    if ($isunknown(got) || got < lo || got > hi) begin
      bad_count++;
      $display("[ERR] %s expected %0h..%0h seen %0h", name, lo, hi, got);
    end
  endtask

  task automatic readCount();
    wbCycle(timer_pkg::ADDR_COUNT_LOW, 1'b0, 8'h00);
    cnt[7:0] = q;
    wbCycle(timer_pkg::ADDR_COUNT_HIGH, 1'b0, 8'h00);
    cnt[15:8] = q;
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check("flags", 16'h0000, 16'h0000, {13'h0000, ampEn, ovf, wake});
    for (int a = 0; a <= 20; a += 4) begin
      wbCycle(5'(a), 1'b0, 8'h00);
      check("reset reg", 16'h0000, 16'h0000, {8'h00, q});
    end
    wr(5'h14, 8'hFF);
    wbCycle(5'h14, 1'b0, 8'h00);
    check("unmapped", 16'h0000, 16'h0000, {8'h00, q});
    wr(timer_pkg::ADDR_COUNT_LOW, 8'hA5);
    wr(timer_pkg::ADDR_COUNT_HIGH, 8'h5A);
    readCount();
    check("byte write", 16'h5AA5, 16'h5AA5, cnt);
    foreach (rows[i]) begin
      r = rows[i];
      gateLevel <= r.gate;
      runExt <= r.ext;
      wr(timer_pkg::ADDR_GATE_CTRL, r.gctrl);
      wr(timer_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(timer_pkg::ADDR_COUNT_HIGH, 8'h00);
      wr(timer_pkg::ADDR_TIMER_CTRL, r.ctrl & 8'hFE);
      repeat (20) @(posedge clock);
      wr(timer_pkg::ADDR_TIMER_CTRL, r.ctrl);
      repeat (RUN) @(posedge clock);
      wr(timer_pkg::ADDR_TIMER_CTRL, r.ctrl & 8'hFE);
      check("amp enable", {15'h0000, r.ctrl[3]}, {15'h0000, r.ctrl[3]}, {15'h0000, ampEn});
      readCount();
      ctr = (r.div == 0) ? 0 : (RUN + 3) / r.div;
      check("count", 16'((r.div == 0) ? 0 : ctr - 2), 16'((r.div == 0) ? 0 : ctr + 2), cnt);
    end
    // The gate level shows through the pin register and both synchroniser stages.
    gateLevel <= 1'b1;
    repeat (4) @(posedge clock);
    wbCycle(timer_pkg::ADDR_GATE_CTRL, 1'b0, 8'h00);
    check("gate level", 16'h0002, 16'h0002, {8'h00, q & 8'h02});
    gateLevel <= 1'b0;
    runExt <= 1'b0;
    wr(timer_pkg::ADDR_GATE_CTRL, 8'h00);
    wr(timer_pkg::ADDR_COUNT_HIGH, 8'hFF);
    wr(timer_pkg::ADDR_COUNT_LOW, 8'hFE);
    wr(timer_pkg::ADDR_TIMER_CTRL, 8'h85);
    sleepMode <= 1'b1;
    runExt <= 1'b1;
    repeat (32) @(posedge clock);
    runExt <= 1'b0;
    repeat (8) @(posedge clock);
    check("wake", 16'h0001, 16'h0001, {15'h0000, wake});
    sleepMode <= 1'b0;
    wr(timer_pkg::ADDR_TIMER_CTRL, 8'h84);
    readCount();
    check("sleep count", 16'h0001, 16'h0001, cnt);
    repeat (20) @(posedge clock);
    wbCycle(timer_pkg::ADDR_STATUS, 1'b0, 8'h00);
    check("overflow", 16'h0001, 16'h0001, {8'h00, q});
    wr(timer_pkg::ADDR_STATUS, 8'h00);
    @(negedge clock);
    check("cleared", 16'h0000, 16'h0000, {15'h0000, ovf});
    report_and_stop();
  end
endmodule
